/* File: design/dcec_pkg.sv */
// shared constants for the channel event control block
// assumes one 200 MHz clock and a 32-bit apb register port
package dcec_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SEL_W = 8;
    localparam int SIZE_W = 16;
    localparam int IRQ_N = 256;
    localparam int INT_W = 2;

    // register byte offsets
    localparam logic [ADDR_W-1:0] ECON_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] CSIZ_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] ISTAT_OFS = 8'h0C;
    localparam logic [ADDR_W-1:0] ICLR_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] IEN_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] CPTR_OFS = 8'h18;

    // event control and control register field positions
    localparam int ABORT_SEL_LSB = 16;
    localparam int START_SEL_LSB = 8;
    localparam int FORCE_BIT = 7;
    localparam int ABORT_BIT = 6;
    localparam int PAT_BIT = 5;
    localparam int SIRQ_BIT = 4;
    localparam int AIRQ_BIT = 3;
    localparam int CHANNEL_ENABLE_BIT = 0;

    // interrupt status bit positions
    localparam int INT_ABORT_BIT = 0;
    localparam int INT_DONE_BIT = 1;

    // reset values
    localparam logic [SEL_W-1:0] SEL_RST = 8'hFF;
    localparam logic [SIZE_W-1:0] SIZE_RST = 16'h0000;
    localparam logic [SIZE_W-1:0] SIZE_ONE = 16'h0001;
    localparam logic [INT_W-1:0] INT_RST = 2'h0;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

    typedef logic [SIZE_W-1:0] dcec_size_t;
    typedef logic [SEL_W-1:0] dcec_sel_t;
endpackage

/* File: design/dcec_seq.sv */
// cell transfer sequencer: moves cellSize bytes per start, one per ack
// assumes start and abort are single-cycle pulses on the same clock
`timescale 1ns/1ps
module dcec_seq (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control side
    dcec_seq_if.seq sq
);
    import dcec_pkg::*;

    typedef enum logic {IDLE, MOVE} dcec_state_e;
    dcec_state_e state_q, state_d;
    dcec_size_t count_q, count_d;
    logic done_q, done_d;

    ////////////////////////////////////////////////////////////////////////
    // next state: abort wins over everything and drops the cell
    always_comb begin
        state_d = state_q;
        count_d = count_q;
        done_d = 1'b0;
        case (state_q)
            IDLE: begin
                if (sq.start && !sq.abort && sq.cellSize != SIZE_RST) begin
                    state_d = MOVE;
                    count_d = SIZE_RST;
                end
            end
            MOVE: begin
                if (sq.abort) begin
                    state_d = IDLE;
                end else if (sq.byteAck) begin
                    count_d = count_q + SIZE_ONE;
                    if (count_q + SIZE_ONE == sq.cellSize) begin
                        state_d = IDLE;
                        done_d = 1'b1;
                    end
                end
            end
            default: state_d = IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= IDLE;
            count_q <= SIZE_RST;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            done_q <= done_d;
        end
    end

    assign sq.busy = (state_q == MOVE);
    assign sq.byteReq = (state_q == MOVE);
    assign sq.byteCount = count_q;
    assign sq.cellDone = done_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    abort_to_idle_a: assert property (sq.abort |=> !sq.busy && !sq.cellDone)
        else $error("abort did not return sequencer to idle");
    cell_length_a: assert property ((state_q == MOVE && sq.byteAck && !sq.abort
        && count_q + SIZE_ONE == sq.cellSize) |=> sq.cellDone && !sq.busy)
        else $error("cell did not end after cellSize bytes");
    count_step_a: assert property ((sq.busy && sq.byteAck && !sq.abort && !sq.cellDone)
        |=> sq.byteCount == $past(count_q) + SIZE_ONE || !sq.busy)
        else $error("byte count did not advance on ack");
endmodule

/* File: design/dcec_seq_if.sv */
// signals between the event control and the cell transfer sequencer
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface dcec_seq_if;
    import dcec_pkg::*;
    logic start;
    logic abort;
    dcec_size_t cellSize;
    logic byteAck;
    logic busy;
    logic byteReq;
    dcec_size_t byteCount;
    logic cellDone;

    modport ctrl (output start, abort, cellSize, byteAck,
                  input busy, byteReq, byteCount, cellDone);
    modport seq (input start, abort, cellSize, byteAck,
                 output busy, byteReq, byteCount, cellDone);
endinterface

/* File: design/dcec_top.sv */
// channel event control: irq-selected start and abort, force and abort
// strobes, pattern abort, cell size, apb registers and one interrupt
// assumes irq lines and pattern match are one-cycle pulses on clk
//
// Contract
// - abort selector picks irq 0..255, sets flag
// - start selector picks irq 0..255 to start
// - start enable one and channel enable one: matching irq starts cell
// - start enable zero: selected irq ignored
// - abort enable one: matching irq aborts transfer
// - abort enable zero: selected irq ignored
// - writing force bit starts transfer immediately
// - writing abort bit aborts transfer
// - force/abort bits write-one only, read zero
// - pattern enable: match aborts, clears channel enable
// - pattern enable zero: matches have no effect
// - event control bits 2:0, 31:24 read zero
// - cell size sets bytes moved per start
`timescale 1ns/1ps
module dcec_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic [dcec_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dcec_pkg::DATA_W-1:0] pwdata,
    output logic pready,
    output logic [dcec_pkg::DATA_W-1:0] prdata,
    output logic pslverr,
    // interrupt request lines
    input wire logic [dcec_pkg::IRQ_N-1:0] irqLines,
    // transfer datapath
    input wire logic patternMatch,
    input wire logic byteAck,
    output logic byteReq,
    output logic xferBusy,
    output logic channelEnable,
    // interrupt to cpu
    output logic irq
);
    import dcec_pkg::*;

    // true when the line chosen by sel carries an event
    function automatic logic irqHit(input logic [IRQ_N-1:0] lines, input dcec_sel_t sel);
        irqHit = lines[sel];
    endfunction

    dcec_seq_if sqBus ();

    dcec_sel_t abortSel_q, abortSel_d;
    dcec_sel_t startSel_q, startSel_d;
    logic pattern_abort_enable_q, pattern_abort_enable_d;
    logic start_request_enable_q, start_request_enable_d;
    logic abort_request_enable_q, abort_request_enable_d;
    logic channel_enable_q, channel_enable_d;
    dcec_size_t cellSize_q, cellSize_d;
    logic [INT_W-1:0] intStat_q, intStat_d;
    logic [INT_W-1:0] intEn_q, intEn_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic slverr_q, slverr_d;

    logic setupRd;
    logic accWr;
    logic econWr;
    logic forceWr;
    logic abortWr;
    logic startHit;
    logic abortHit;
    logic patAbort;
    logic startEv;
    logic abortEv;
    logic mapped;

    ////////////////////////////////////////////////////////////////////////
    // apb decode: zero-wait access, read data latched in setup
    assign setupRd = psel && !penable;
    assign accWr = psel && penable && pwrite;
    assign econWr = accWr && paddr == ECON_OFS;
    assign forceWr = econWr && pwdata[FORCE_BIT];
    assign abortWr = econWr && pwdata[ABORT_BIT];
    assign pready = psel && penable;
    assign prdata = rdata_q;
    assign pslverr = slverr_q && psel && penable;

    // address map check
    always_comb begin
        if (paddr == ECON_OFS) begin
            mapped = 1'b1;
        end else if (paddr == CSIZ_OFS || paddr == CTRL_OFS) begin
            mapped = 1'b1;
        end else if (paddr == ISTAT_OFS || paddr == ICLR_OFS || paddr == IEN_OFS) begin
            mapped = 1'b1;
        end else if (paddr == CPTR_OFS) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event sources
    assign startHit = start_request_enable_q && irqHit(irqLines, startSel_q);
    assign abortHit = abort_request_enable_q && irqHit(irqLines, abortSel_q);
    assign patAbort = pattern_abort_enable_q && patternMatch;
    assign abortEv = abortHit || abortWr || patAbort;
    // irq starts need the channel on; a forced start does not
    assign startEv = (startHit && channel_enable_q) || forceWr;

    assign sqBus.start = startEv;
    assign sqBus.abort = abortEv;
    assign sqBus.cellSize = cellSize_q;
    assign sqBus.byteAck = byteAck;

    dcec_seq u_seq (
        .clk(clk),
        .rst_n(rst_n),
        .sq(sqBus)
    );

    ////////////////////////////////////////////////////////////////////////
    // register next values
    always_comb begin
        abortSel_d = abortSel_q;
        startSel_d = startSel_q;
        pattern_abort_enable_d = pattern_abort_enable_q;
        start_request_enable_d = start_request_enable_q;
        abort_request_enable_d = abort_request_enable_q;
        channel_enable_d = channel_enable_q;
        cellSize_d = cellSize_q;
        intEn_d = intEn_q;
        intStat_d = intStat_q;
        rdata_d = rdata_q;
        slverr_d = slverr_q;
        if (accWr) begin
            if (paddr == ECON_OFS) begin
                abortSel_d = pwdata[ABORT_SEL_LSB +: SEL_W];
                startSel_d = pwdata[START_SEL_LSB +: SEL_W];
                pattern_abort_enable_d = pwdata[PAT_BIT];
                start_request_enable_d = pwdata[SIRQ_BIT];
                abort_request_enable_d = pwdata[AIRQ_BIT];
            end else if (paddr == CSIZ_OFS) begin
                cellSize_d = pwdata[SIZE_W-1:0];
            end else if (paddr == CTRL_OFS) begin
                channel_enable_d = pwdata[CHANNEL_ENABLE_BIT];
            end else if (paddr == ICLR_OFS) begin
                intStat_d = intStat_q & ~pwdata[INT_W-1:0];
            end else if (paddr == IEN_OFS) begin
                intEn_d = pwdata[INT_W-1:0];
            end
        end
        // pattern abort turns the channel off, after any software write
        if (patAbort) begin
            channel_enable_d = 1'b0;
        end
        // hardware set wins over a clear in the same cycle
        if (abortEv) begin
            intStat_d[INT_ABORT_BIT] = 1'b1;
        end
        if (sqBus.cellDone) begin
            intStat_d[INT_DONE_BIT] = 1'b1;
        end
        // read data captured in the setup cycle
        if (setupRd) begin
            rdata_d = WORD_ZERO;
            slverr_d = !mapped;
            if (!pwrite) begin
                if (paddr == ECON_OFS) begin
                    // strobes and unused bits read zero
                    rdata_d[ABORT_SEL_LSB +: SEL_W] = abortSel_q;
                    rdata_d[START_SEL_LSB +: SEL_W] = startSel_q;
                    rdata_d[PAT_BIT] = pattern_abort_enable_q;
                    rdata_d[SIRQ_BIT] = start_request_enable_q;
                    rdata_d[AIRQ_BIT] = abort_request_enable_q;
                end else if (paddr == CSIZ_OFS) begin
                    rdata_d[SIZE_W-1:0] = cellSize_q;
                end else if (paddr == CTRL_OFS) begin
                    rdata_d[CHANNEL_ENABLE_BIT] = channel_enable_q;
                end else if (paddr == ISTAT_OFS) begin
                    rdata_d[INT_W-1:0] = intStat_q;
                end else if (paddr == IEN_OFS) begin
                    rdata_d[INT_W-1:0] = intEn_q;
                end else if (paddr == CPTR_OFS) begin
                    rdata_d[SIZE_W-1:0] = sqBus.byteCount;
                end
            end
        end
    end

    // register storage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            abortSel_q <= SEL_RST;
            startSel_q <= SEL_RST;
            pattern_abort_enable_q <= 1'b0;
            start_request_enable_q <= 1'b0;
            abort_request_enable_q <= 1'b0;
            channel_enable_q <= 1'b0;
            cellSize_q <= SIZE_RST;
            intStat_q <= INT_RST;
            intEn_q <= INT_RST;
            rdata_q <= WORD_ZERO;
            slverr_q <= 1'b0;
        end else begin
            abortSel_q <= abortSel_d;
            startSel_q <= startSel_d;
            pattern_abort_enable_q <= pattern_abort_enable_d;
            start_request_enable_q <= start_request_enable_d;
            abort_request_enable_q <= abort_request_enable_d;
            channel_enable_q <= channel_enable_d;
            cellSize_q <= cellSize_d;
            intStat_q <= intStat_d;
            intEn_q <= intEn_d;
            rdata_q <= rdata_d;
            slverr_q <= slverr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign byteReq = sqBus.byteReq;
    assign xferBusy = sqBus.busy;
    assign channelEnable = channel_enable_q;
    assign irq = |(intStat_q & intEn_q);

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    start_on_irq_a: assert property ((start_request_enable_q && channel_enable_q && irqLines[startSel_q]
        && !abortEv && !xferBusy && cellSize_q != SIZE_RST) |=> xferBusy)
        else $error("selected start irq did not start a cell");
    start_gated_a: assert property ((!start_request_enable_q && !forceWr && !xferBusy)
        |=> !xferBusy)
        else $error("transfer started with start irq disabled");
    abort_on_irq_a: assert property ((abort_request_enable_q && irqLines[abortSel_q])
        |=> !xferBusy && intStat_q[INT_ABORT_BIT])
        else $error("selected abort irq did not abort");
    abort_gated_a: assert property ((xferBusy && !abort_request_enable_q && !abortWr && !patAbort
        && !byteAck) |=> xferBusy)
        else $error("transfer ended with abort irq disabled");
    force_start_a: assert property ((forceWr && !abortEv && !xferBusy
        && cellSize_q != SIZE_RST) |=> xferBusy)
        else $error("force write did not start transfer");
    abort_strobe_a: assert property (abortWr |=> !xferBusy ##0 intStat_q[INT_ABORT_BIT])
        else $error("abort write did not abort transfer");
    strobe_read_zero_a: assert property ((setupRd && !pwrite && paddr == ECON_OFS)
        |=> prdata[FORCE_BIT] == 1'b0 && prdata[ABORT_BIT] == 1'b0)
        else $error("strobe bits read nonzero");
    pattern_abort_a: assert property ((pattern_abort_enable_q && patternMatch)
        |=> !channelEnable && !xferBusy)
        else $error("pattern match did not abort and disable");
    pattern_off_a: assert property ((!pattern_abort_enable_q && channel_enable_q && !(accWr && paddr == CTRL_OFS))
        |=> channelEnable)
        else $error("channel enable cleared with pattern abort off");
    econ_unused_a: assert property ((setupRd && !pwrite && paddr == ECON_OFS)
        |=> prdata[31:24] == 8'h00 && prdata[2:0] == 3'h0)
        else $error("unused event control bits read nonzero");
endmodule

/* File: dv/dcec_dp_model.sv */
// transfer datapath model: takes one byte per byteAck, at full rate or
// on alternate cycles, and counts the bytes of the current cell
// assumes byteReq comes from the channel on the same clock
`timescale 1ns/1ps
module dcec_dp_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // channel side
    input wire logic byteReq,
    output logic byteAck,
    // bench control and byte count
    input wire logic slow,
    output logic [15:0] ackCnt
);
    logic phaseQ_q;
    logic reqLast_q;

    // slow mode stalls every other cycle so aborts land mid-cell
    assign byteAck = byteReq & (~slow | phaseQ_q);

    // count restarts on the first cycle of each cell
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phaseQ_q <= 1'b0;
            reqLast_q <= 1'b0;
            ackCnt <= 16'h0000;
        end else begin
            phaseQ_q <= ~phaseQ_q;
            reqLast_q <= byteReq;
            if (byteReq && !reqLast_q) begin
                ackCnt <= 16'(byteAck);
            end else if (byteAck) begin
                ackCnt <= ackCnt + 16'h0001;
            end
        end
    end
endmodule

/* File: dv/dcec_top_tb.sv */
// self-checking bench for the channel event control block
// assumes the datapath model and a 200 MHz clock; apb master is a task
`timescale 1ns/1ps
module dcec_top_tb;
    import dcec_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [DATA_W-1:0] pwdata = 32'h0;
    logic pready, pslverr, byteAck, byteReq, xferBusy, channelEnable, irq;
    logic [DATA_W-1:0] prdata;
    logic [IRQ_N-1:0] irqLines = '0;
    logic patternMatch = 1'b0;
    logic slow = 1'b0;
    logic [15:0] ackCnt;
    logic [31:0] rd, w;
    logic err;
    logic [7:0] ss;
    logic [15:0] n;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 32'hB13C;

    dcec_top i_dcec_top (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .irqLines(irqLines),
        .patternMatch(patternMatch), .byteAck(byteAck), .byteReq(byteReq),
        .xferBusy(xferBusy), .channelEnable(channelEnable), .irq(irq));
    dcec_dp_model i_dcec_dp_model (.clk(clk), .rst_n(rst_n), .byteReq(byteReq),
        .byteAck(byteAck), .slow(slow), .ackCnt(ackCnt));

    always #2.5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    // expected event control readback: strobes and unused bits read zero
    function automatic logic [31:0] econ_exp(input logic [31:0] v);
        return v & 32'h00FF_FF38;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer: setup, access held until pready sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one-cycle event pulse; index 256 is the pattern match line
    task automatic pulse(input int i);
        @(posedge clk);
        if (i < IRQ_N) irqLines[i] <= 1'b1;
        else patternMatch <= 1'b1;
        @(posedge clk);
        irqLines <= '0;
        patternMatch <= 1'b0;
        @(negedge clk);
    endtask

    task automatic wait_idle;
        int k;
        k = 0;
        while (byteReq !== 1'b0 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        // done flag reaches status two edges after the last byte
        repeat (2) @(negedge clk);
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, random readback, unmapped access
        apb(1'b0, ECON_OFS, 32'h0);
        chk("econ reset", 32'h00FF_FF00, rd);
        apb(1'b0, CSIZ_OFS, 32'h0);
        chk("csiz reset", 32'h0, rd);
        repeat (8) begin
            w = $random(seed);
            apb(1'b1, ECON_OFS, w);
            apb(1'b0, ECON_OFS, 32'h0);
            chk("econ read", econ_exp(w), rd);
            w = $random(seed);
            apb(1'b1, CSIZ_OFS, w);
            apb(1'b0, CSIZ_OFS, 32'h0);
            chk("csiz read", w & 32'h0000_FFFF, rd);
        end
        // a random force bit may have started a long cell: stop it
        apb(1'b1, ECON_OFS, 32'h0000_0040);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        $display("test registers done");
        apb(1'b1, IEN_OFS, 32'h2);
        apb(1'b1, CTRL_OFS, 32'h1);
        apb(1'b1, ICLR_OFS, 32'h3);
        // irq-started cells of random and boundary sizes and selectors
        for (int t = 0; t < 6; t++) begin
            n = 16'($random(seed) & 7) + 16'h0001;
            ss = 8'($random(seed));
            if (t == 0) n = 16'h0001;
            if (t == 5) n = 16'h0100;
            if (t == 1) ss = 8'h00;
            if (t == 2) ss = 8'hFF;
            slow <= t[0];
            apb(1'b1, CSIZ_OFS, {16'h0, n});
            apb(1'b1, ECON_OFS, {8'h0, ~ss, ss, 8'h10});
            pulse(ss);
            chk("irq start", 32'h1, 32'(byteReq));
            wait_idle();
            chk("cell bytes", 32'(n), 32'(ackCnt));
            chk("done irq", 32'h1, 32'(irq));
            apb(1'b1, ICLR_OFS, 32'h3);
            @(negedge clk);
            chk("irq cleared", 32'h0, 32'(irq));
        end
        $display("test irq start done");
        // start enable off: selected irq ignored
        apb(1'b1, ECON_OFS, {8'h0, ~ss, ss, 8'h00});
        pulse(ss);
        repeat (3) @(negedge clk);
        chk("start ignored", 32'h0, 32'(byteReq));
        // abort by irq mid-cell, then with abort enable off
        slow <= 1'b1;
        apb(1'b1, CSIZ_OFS, 32'h0000_0040);
        apb(1'b1, ECON_OFS, {8'h0, ~ss, ss, 8'h18});
        pulse(ss);
        repeat (5) @(posedge clk);
        pulse(~ss);
        chk("irq abort", 32'h0, 32'(byteReq));
        chk("abort partial", 32'h1, 32'(ackCnt < 16'h0040));
        apb(1'b0, ISTAT_OFS, 32'h0);
        chk("abort flag", 32'h1, rd & 32'h1);
        apb(1'b1, ICLR_OFS, 32'h3);
        apb(1'b1, ECON_OFS, {8'h0, ~ss, ss, 8'h10});
        pulse(ss);
        pulse(~ss);
        chk("abort ignored", 32'h1, 32'(byteReq));
        wait_idle();
        chk("full cell", 32'h40, 32'(ackCnt));
        apb(1'b0, CPTR_OFS, 32'h0);
        chk("cell pointer", 32'h40, rd);
        $display("test irq abort done");
        // software force then software abort
        apb(1'b1, ECON_OFS, 32'h0000_0080);
        @(negedge clk);
        chk("force start", 32'h1, 32'(byteReq));
        apb(1'b1, ECON_OFS, 32'h0000_0040);
        @(negedge clk);
        chk("soft abort", 32'h0, 32'(byteReq));
        apb(1'b0, ECON_OFS, 32'h0);
        chk("strobes read", 32'h0, rd & 32'h0000_00C0);
        $display("test soft strobes done");
        // pattern abort enabled, then disabled
        apb(1'b1, ECON_OFS, 32'h0000_00A0);
        repeat (3) @(posedge clk);
        pulse(256);
        chk("pattern abort", 32'h0, 32'(byteReq));
        chk("pattern channel_enable", 32'h0, 32'(channelEnable));
        apb(1'b1, CTRL_OFS, 32'h1);
        apb(1'b1, ECON_OFS, 32'h0000_0080);
        pulse(256);
        chk("pattern off", 32'h1, 32'(byteReq));
        chk("channel_enable kept", 32'h1, 32'(channelEnable));
        wait_idle();
        $display("test pattern done");
        // interrupt masking on the abort flag
        apb(1'b1, ICLR_OFS, 32'h3);
        apb(1'b1, IEN_OFS, 32'h0);
        apb(1'b1, ECON_OFS, 32'h0000_0040);
        @(negedge clk);
        chk("masked irq", 32'h0, 32'(irq));
        apb(1'b1, IEN_OFS, 32'h1);
        @(negedge clk);
        chk("unmasked irq", 32'h1, 32'(irq));
        apb(1'b1, ICLR_OFS, 32'h1);
        @(negedge clk);
        chk("cleared irq", 32'h0, 32'(irq));
        $display("test interrupt done");
        complete_run();
    end
endmodule
